// ### acr_top.v
// Converter control and result registers behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "acr_map.vh"
// Behaviour
// - Single mode converts once, result after 5129 system cycles.
// - Repeat mode refreshes the result every 256 system cycles.
// - Channel codes 0 to 11 select inputs 0 to 11; 11xx reserved.
// - High register holds result bits 9 to 2 in bits 7 to 0.
// - High register content invalid during a single conversion.
// - High register is read-only.
// - Reading high register captures the matching two low bits.
// - Low register bits 7:6 return low bits of last high read.
// - In repeat mode high register keeps last result until replaced.
// - Result registers are undefined after reset, not initialised.
// - Low register bits 5 to 0 are reserved, value undefined.
// - Low register is read-only.
// - Full result is high byte then low register bits 7:6.
// - Writing go bit 1 starts or restarts; 0 no effect; clears on done.
// - In repeat mode go bit clears at first completion, stays clear.
// - Every completed conversion sets the done status; interrupt request only while its enable bit is set.
// - Power down after 160 idle cycles; 40 cycles to power up.
module acr_top #(
  parameter SINGLE_CYC = `ACR_CYC_SINGLE,
  parameter REPEAT_CYC = `ACR_CYC_REPEAT,
  parameter RES_W = 10
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [RES_W-1:0] modulator_result,
  output reg [3:0] channel_select_ff,
  output reg vref_disable_ff,
  output reg converter_power_ff,
  output reg converter_clk_en_ff,
  output reg irq_ff
);
  localparam RESP_OK = 2'h0;
  localparam RESP_ERR = 2'h2;
  reg [7:0] ctrl_ff;
  reg [RES_W-1:0] result_ff;
  reg [1:0] low_latch_ff;
  reg [1:0] status_ff;
  reg [1:0] ien_ff;
  reg [11:0] awaddr_ff;
  reg aw_held_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg w_held_ff;
  reg [1:0] nxt_status;
  reg [7:0] nxt_ctrl;
  wire seq_done;
  wire seq_first;
  wire seq_busy;
  wire seq_powered;
  wire [1:0] seq_phase;
  wire wr_fire;
  wire rd_fire;
  wire ctrl_wr;
  wire clr_wr;
  wire go_wr;

  function known_addr;
    input [11:0] a;
    begin
      known_addr = (a == `ACR_IDX_CTRL) || (a == `ACR_IDX_HIGH) || (a == `ACR_IDX_LOW) ||
                   (a == `ACR_IDX_STAT) || (a == `ACR_IDX_CLR) || (a == `ACR_IDX_IEN);
    end
  endfunction

  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign ctrl_wr = wr_fire && (awaddr_ff == `ACR_IDX_CTRL) && wstrb_ff[0];
  assign clr_wr = wr_fire && (awaddr_ff == `ACR_IDX_CLR) && wstrb_ff[0];
  assign go_wr = ctrl_wr && wdata_ff[`ACR_CTRL_GO];

  acr_seq #(
    .SINGLE_CYC(SINGLE_CYC),
    .REPEAT_CYC(REPEAT_CYC),
    .IDLE_CYC(`ACR_CYC_IDLE),
    .PWRUP_CYC(`ACR_CYC_POWERUP)
  ) u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(go_wr),
    .repeat_mode(ctrl_ff[`ACR_CTRL_REPEAT]),
    .done(seq_done),
    .first_done(seq_first),
    .busy(seq_busy),
    .powered(seq_powered),
    .conv_phase(seq_phase)
  );

  // Write channels are taken independently and held until both are here
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held_ff && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_ff && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[11:0]};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known_addr(awaddr_ff) ? RESP_OK : RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Go bit: hardware clear only on first completion, and a new go wins
  always @* begin
    nxt_ctrl = ctrl_ff;
    if (seq_first) begin
      nxt_ctrl[`ACR_CTRL_GO] = 1'b0;
    end
    if (ctrl_wr) begin
      nxt_ctrl[6:0] = {1'b0, wdata_ff[5:0]};
      if (wdata_ff[`ACR_CTRL_GO]) begin
        nxt_ctrl[`ACR_CTRL_GO] = 1'b1;
      end
    end
  end

  // Sticky events: set beats a clear in the same cycle
  always @* begin
    nxt_status = status_ff;
    if (clr_wr) begin
      nxt_status = status_ff & ~wdata_ff[1:0];
    end
    if (seq_done) begin
      nxt_status[`ACR_ST_DONE] = 1'b1;
    end
    if (go_wr && (wdata_ff[3:2] == 2'b11)) begin
      nxt_status[`ACR_ST_BADCH] = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `ACR_RST_CTRL;
      status_ff <= 2'h0;
      ien_ff <= `ACR_RST_IEN;
      irq_ff <= 1'b0;
      channel_select_ff <= 4'h0;
      vref_disable_ff <= 1'b0;
      converter_power_ff <= 1'b0;
      converter_clk_en_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      status_ff <= nxt_status;
      if (wr_fire && (awaddr_ff == `ACR_IDX_IEN) && wstrb_ff[0]) begin
        ien_ff <= wdata_ff[1:0];
      end
      irq_ff <= |(nxt_status & ien_ff);
      // Reserved codes leave the previous channel selected
      if (nxt_ctrl[3:0] <= `ACR_CHAN_LAST) begin
        channel_select_ff <= nxt_ctrl[3:0];
      end
      vref_disable_ff <= nxt_ctrl[`ACR_CTRL_VREF];
      converter_power_ff <= seq_powered || seq_busy;
      // No converter ticks until the power-up wait has run out
      converter_clk_en_ff <= seq_busy && seq_powered && (seq_phase == 2'h3);
    end
  end

  // Result storage has no reset; it is undefined until the first completion
  always @(posedge aclk) begin
    if (seq_done) begin
      result_ff <= modulator_result;
    end
    if (rd_fire && (s_axi_araddr == `ACR_IDX_HIGH)) begin
      low_latch_ff <= result_ff[1:0];
    end
  end

  // Read side; result registers have no write path at all
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= known_addr(s_axi_araddr) ? RESP_OK : RESP_ERR;
        case (s_axi_araddr)
          `ACR_IDX_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_ff};
          `ACR_IDX_HIGH: s_axi_rdata <= {24'h00_0000, result_ff[9:2]};
          // Reserved low bits read as zero
          `ACR_IDX_LOW: s_axi_rdata <= {24'h00_0000, low_latch_ff, 6'h00};
          `ACR_IDX_STAT: s_axi_rdata <= {30'h0000_0000, status_ff};
          `ACR_IDX_IEN: s_axi_rdata <= {30'h0000_0000, ien_ff};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // Writes to high/low addresses fall through decode untouched
endmodule

// ### acr_map.vh
// Register map, field positions and timing counts of the converter control block
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
// Byte addresses on the register bus (index plus 0x0f70)
`define ACR_IDX_CTRL 12'h0f70
`define ACR_IDX_HIGH 12'h0f72
`define ACR_IDX_LOW 12'h0f73
`define ACR_IDX_STAT 12'h0f74
`define ACR_IDX_CLR 12'h0f75
`define ACR_IDX_IEN 12'h0f76
// Control fields
`define ACR_CTRL_GO 7
`define ACR_CTRL_VREF 5
`define ACR_CTRL_REPEAT 4
`define ACR_CTRL_CHAN_HI 3
`define ACR_CTRL_CHAN_LO 0
`define ACR_CHAN_LAST 4'h0b
// Status fields
`define ACR_ST_DONE 0
`define ACR_ST_BADCH 1
// Reset values
`define ACR_RST_CTRL 8'h00
`define ACR_RST_IEN 2'h0
// Timing counts in system clock cycles
`define ACR_CYC_SINGLE 5129
`define ACR_CYC_REPEAT 256
`define ACR_CYC_IDLE 160
`define ACR_CYC_POWERUP 40
// Converter clock divides system clock by this
`define ACR_DIV 4
`endif

// ### acr_seq.v
// Conversion sequencer: power-up, single and repeat timing, idle power-down
module acr_seq #(
  parameter SINGLE_CYC = 5129,
  parameter REPEAT_CYC = 256,
  parameter IDLE_CYC = 160,
  parameter PWRUP_CYC = 40
) (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire repeat_mode,
  output reg done,
  output reg first_done,
  output reg busy,
  output reg powered,
  output reg [1:0] conv_phase
);
  localparam S_IDLE = 2'd0;
  localparam S_PWRUP = 2'd1;
  localparam S_FIRST = 2'd2;
  localparam S_REPEAT = 2'd3;
  reg [1:0] state_ff;
  reg [12:0] cnt_ff;
  reg [7:0] idle_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= S_IDLE;
      cnt_ff <= 13'h0000;
      idle_ff <= 8'h00;
      done <= 1'b0;
      first_done <= 1'b0;
      busy <= 1'b0;
      powered <= 1'b0;
      conv_phase <= 2'h0;
    end else begin
      done <= 1'b0;
      first_done <= 1'b0;
      conv_phase <= conv_phase + 2'h1;
      if (start) begin
        // Restart also covers a running conversion
        busy <= 1'b1;
        idle_ff <= 8'h00;
        cnt_ff <= 13'h0000;
        state_ff <= powered ? S_FIRST : S_PWRUP;
      end else begin
        case (state_ff)
          S_IDLE: begin
            busy <= 1'b0;
            if (powered) begin
              if (idle_ff == IDLE_CYC[7:0] - 8'h01) begin
                powered <= 1'b0;
              end else begin
                idle_ff <= idle_ff + 8'h01;
              end
            end
          end
          S_PWRUP: begin
            if (cnt_ff == PWRUP_CYC[12:0] - 13'h0001) begin
              powered <= 1'b1;
              cnt_ff <= 13'h0000;
              state_ff <= S_FIRST;
            end else begin
              cnt_ff <= cnt_ff + 13'h0001;
            end
          end
          S_FIRST: begin
            powered <= 1'b1;
            if (cnt_ff == SINGLE_CYC[12:0] - 13'h0001) begin
              done <= 1'b1;
              first_done <= 1'b1;
              cnt_ff <= 13'h0000;
              if (repeat_mode) begin
                state_ff <= S_REPEAT;
              end else begin
                state_ff <= S_IDLE;
                busy <= 1'b0;
                idle_ff <= 8'h00;
              end
            end else begin
              cnt_ff <= cnt_ff + 13'h0001;
            end
          end
          S_REPEAT: begin
            // Clearing repeat mode stops after the current period
            if (cnt_ff == REPEAT_CYC[12:0] - 13'h0001) begin
              done <= 1'b1;
              cnt_ff <= 13'h0000;
              if (!repeat_mode) begin
                state_ff <= S_IDLE;
                busy <= 1'b0;
                idle_ff <= 8'h00;
              end
            end else begin
              cnt_ff <= cnt_ff + 13'h0001;
            end
          end
          default: begin
            state_ff <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ### acr_chk.sv
// Port-level checker of the converter control block
module acr_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_arready,
  input wire [3:0] channel_select_ff,
  input wire converter_power_ff,
  input wire converter_clk_en_ff,
  input wire irq_ff
);
  logic [7:0] quiet_ff;
  logic [7:0] up_ff;
  // Saturating counters: cycles since last converter tick, cycles powered
  always @(posedge aclk) begin
    if (!aresetn || converter_clk_en_ff) quiet_ff <= 8'h00;
    else if (quiet_ff != 8'hff) quiet_ff <= quiet_ff + 8'h01;
    if (!converter_power_ff) up_ff <= 8'h00;
    else if (up_ff != 8'hff) up_ff <= up_ff + 8'h01;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_clken_quarter: assert property (converter_clk_en_ff |=> !converter_clk_en_ff [*3])
    else $error("converter tick faster than a quarter of the clock");
  chk_clken_powered: assert property (converter_clk_en_ff |-> converter_power_ff)
    else $error("converter ticks while powered down");
  chk_power_idle: assert property ($fell(converter_power_ff) |-> quiet_ff >= 8'd150 && quiet_ff <= 8'd170)
    else $error("power dropped at wrong idle count");
  chk_powerup_wait: assert property ($rose(converter_clk_en_ff) |-> up_ff >= 8'd36)
    else $error("converter ticks before power-up time");
  chk_chan_range: assert property (channel_select_ff <= 4'hb)
    else $error("reserved channel code reached the mux");
  chk_chan_on_write: assert property (!$stable(channel_select_ff) |-> $rose(s_axi_bvalid))
    else $error("channel changed without a write");
  chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  chk_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  cov_irq: cover property ($rose(irq_ff));
  cov_power_down: cover property ($fell(converter_power_ff));
  cov_chan: cover property (!$stable(channel_select_ff));
endmodule

// ### acr_tb_top.sv
// Testbench of the converter control and result registers
`include "acr_map.vh"
module adc_mode_and_result_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 60;
  localparam int RC = 12;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, pwr, clken, vref;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [9:0] mod_res;
  logic [3:0] chan;
  int n_fail, n_checks, cyc;
  acr_top #(.SINGLE_CYC(SC), .REPEAT_CYC(RC)) acr_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .modulator_result(mod_res), .channel_select_ff(chan), .vref_disable_ff(vref),
    .converter_power_ff(pwr), .converter_clk_en_ff(clken), .irq_ff(irq));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait; a hang counts as a mismatch and closes the run
  task automatic waitfor(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      if (n == lim) begin
        n_fail++;
        results();
      end
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ga, gw;
    int n;
    ga = 1'b0;
    gw = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Address and data may be taken at different edges
    do begin
      @(posedge aclk);
      if (awready && !ga) awvalid <= 1'b0;
      if (wready && !gw) wvalid <= 1'b0;
      ga = ga | awready;
      gw = gw | wready;
      n++;
    end while (!(ga && gw) && n < 50);
    waitfor(bvalid, 50);
    chk(bresp, er);
    bready <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // Address stands until an edge samples arready high
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    waitfor(rvalid, 50);
    chk(rdata, exp);
    rready <= 1'b0;
  endtask
  initial begin
    int t0;
    int k;
    logic [3:0] ex;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    mod_res = 10'h000;
    n_fail = 0;
    n_checks = 0;
    cyc = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`ACR_IDX_CTRL, 32'h0000_0000);
    wr(12'h0ff0, 8'h01, 2'h2);
    $display("test reset done");
    mod_res <= 10'h2d6;
    wr(`ACR_IDX_IEN, 8'h01, 2'h0);
    wr(`ACR_IDX_CTRL, 8'h83, 2'h0);
    t0 = cyc;
    chk(chan, 4'h3);
    rdc(`ACR_IDX_CTRL, 32'h0000_0083);
    waitfor(irq, SC + 100);
    chk(cyc - t0 >= SC + 38 && cyc - t0 <= SC + 44, 32'h0000_0001);
    rdc(`ACR_IDX_CTRL, 32'h0000_0003);
    rdc(`ACR_IDX_HIGH, 32'h0000_00b5);
    mod_res <= 10'h001;
    rdc(`ACR_IDX_LOW, 32'h0000_0080);
    wr(`ACR_IDX_HIGH, 8'hff, 2'h0);
    wr(`ACR_IDX_LOW, 8'hff, 2'h0);
    rdc(`ACR_IDX_HIGH, 32'h0000_00b5);
    rdc(`ACR_IDX_LOW, 32'h0000_0080);
    wr(`ACR_IDX_CLR, 8'h01, 2'h0);
    @(posedge aclk);
    chk(irq, 1'b0);
    $display("test single done");
    ex = 4'h3;
    for (k = 0; k < 16; k++) begin
      wr(`ACR_IDX_CTRL, {4'h0, k[3:0]}, 2'h0);
      if (k < 12) ex = k[3:0];
      chk(chan, ex);
    end
    wr(`ACR_IDX_CTRL, 8'h2e, 2'h0);
    chk({vref, chan}, {1'b1, ex});
    $display("test channel done");
    mod_res <= 10'h3fc;
    wr(`ACR_IDX_CTRL, 8'h95, 2'h0);
    chk({vref, chan}, 5'h05);
    waitfor(irq, SC + 100);
    t0 = cyc;
    wr(`ACR_IDX_CLR, 8'h01, 2'h0);
    @(posedge aclk);
    mod_res <= 10'h155;
    waitfor(irq, RC + 4);
    chk(cyc - t0, RC);
    rdc(`ACR_IDX_HIGH, 32'h0000_0055);
    mod_res <= 10'h002;
    rdc(`ACR_IDX_CTRL, 32'h0000_0015);
    rdc(`ACR_IDX_LOW, 32'h0000_0040);
    wr(`ACR_IDX_CTRL, 8'h05, 2'h0);
    repeat (200) @(posedge aclk);
    chk(pwr, 1'b0);
    $display("test repeat done");
    wr(`ACR_IDX_IEN, 8'h00, 2'h0);
    wr(`ACR_IDX_CLR, 8'h01, 2'h0);
    wr(`ACR_IDX_CTRL, 8'h80, 2'h0);
    repeat (60) @(posedge aclk);
    wr(`ACR_IDX_CTRL, 8'h80, 2'h0);
    repeat (SC - 10) @(posedge aclk);
    rdc(`ACR_IDX_STAT, 32'h0000_0000);
    repeat (20) @(posedge aclk);
    rdc(`ACR_IDX_STAT, 32'h0000_0001);
    chk(irq, 1'b0);
    wr(`ACR_IDX_IEN, 8'h01, 2'h0);
    @(posedge aclk);
    chk(irq, 1'b1);
    $display("test restart done");
    results();
  end
endmodule
bind acr_top acr_chk acr_chk_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_arready(s_axi_arready), .channel_select_ff(channel_select_ff),
  .converter_power_ff(converter_power_ff), .converter_clk_en_ff(converter_clk_en_ff),
  .irq_ff(irq_ff));
